// file: src/fnc_pkg.sv
/*
  Package for the fieldbus node configuration and status block:
  register map, field layouts, switch ranges, bit-rate codes and blink timing.
  Assumes a 10 MHz system clock.
*/
package fnc_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] FNC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] FNC_OFF_PARAM  = 8'h04;
  localparam logic [7:0] FNC_OFF_NET    = 8'h08;
  localparam logic [7:0] FNC_OFF_ACTIVE = 8'h0c;
  localparam logic [7:0] FNC_OFF_IRQ_ST = 8'h10;
  localparam logic [7:0] FNC_OFF_IRQ_MK = 8'h14;

  // ==========================================================================
  // Control register bits
  // Kept above the address, rate and kbit/s fields so that no value aliases a command
  localparam int FNC_CTRL_ADDR_CMD = 26;
  localparam int FNC_CTRL_RATE_CMD = 27;
  localparam int FNC_CTRL_NET_ADDR = 28;
  localparam int FNC_CTRL_NET_RATE = 29;
  localparam int FNC_CTRL_SAVE     = 30;
  localparam int FNC_CTRL_RESTART  = 31;

  // ==========================================================================
  // Parameter register fields
  localparam int FNC_ADDR_LSB = 0;
  localparam int FNC_RATE_LSB = 8;
  localparam int FNC_RATE_KB_LSB = 16;

  // ==========================================================================
  // Network status bits
  localparam int FNC_NET_DUP_DONE = 0;
  localparam int FNC_NET_ONLINE   = 1;
  localparam int FNC_NET_CONN     = 2;
  localparam int FNC_NET_ALLOC    = 3;
  localparam int FNC_NET_CFG_OK   = 4;
  localparam int FNC_NET_RECOV    = 5;
  localparam int FNC_NET_IO_WAIT  = 6;
  localparam int FNC_NET_FATAL    = 7;
  localparam int FNC_NET_DUP_ADDR = 8;
  localparam int FNC_NET_BUS_OFF  = 9;

  // ==========================================================================
  // Interrupt status bits
  localparam int FNC_IRQ_CMD_REJ  = 0;
  localparam int FNC_IRQ_SAVED    = 1;
  localparam int FNC_IRQ_RESTART  = 2;
  localparam int FNC_IRQ_FAULT    = 3;
  localparam int FNC_IRQ_W        = 4;

  // ==========================================================================
  // Switch ranges and bit-rate codes
  localparam logic [6:0] FNC_ADDR_MAX   = 7'h3f;
  localparam logic [1:0] FNC_RATE_MAX   = 2'h2;
  localparam logic [9:0] FNC_KB_125     = 10'h07d;
  localparam logic [9:0] FNC_KB_250     = 10'h0fa;
  localparam logic [9:0] FNC_KB_500     = 10'h1f4;
  localparam logic [5:0] FNC_ADDR_RST   = 6'h3f;
  localparam logic [1:0] FNC_RATE_RST   = 2'h0;

  // ==========================================================================
  // Blink timing: 0.5 s half period
  localparam int FNC_CLK_HZ      = 10_000_000;
  localparam int FNC_BLINK_MS    = 500;
  localparam int FNC_BLINK_CYC   = FNC_CLK_HZ / 1000 * FNC_BLINK_MS;

  typedef enum logic [2:0] {
    FNC_LED_OFF, FNC_LED_GREEN, FNC_LED_BLINK_GREEN, FNC_LED_BLINK_RED, FNC_LED_RED
  } fnc_led_t;

endpackage

// file: src/fnc_node_cfg.sv
/*
  Node configuration and status block: picks station address and bit rate
  from rotary switches or stored parameters, holds a staged/saved parameter
  pair, and drives a two-colour status LED. APB slave for software.
  Assumes synchronous switch and status inputs; nonvolatile storage is
  modelled by the saved registers, which survive a restart but not rst_n.
*/
`timescale 1ns/100ps

// Contract
// - Switch address 0 to 63 is used
// - Address above 63 uses stored parameter
// - Network may write address when switches invalid
// - New values apply after save and restart
// - Rate switch 0,1,2 means 125,250,500 kbit/s
// - Rate switch above 2 uses stored rate
// - Network may write rate code 0 to 2; the code refuses it while the rate switch is 0 to 2
// - LED dark while not online
// - Steady green when online, connected, allocated, configured
// - Blink green when online but not ready
// - Blink red on recoverable error or wait
// - Steady red on fatal or network fault
module fnc_node_cfg
  import fnc_pkg::*;
#(
  parameter int BLINK_CYC = FNC_BLINK_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Rotary switches
  input  wire logic [3:0]  tens_digit_switch,
  input  wire logic [3:0]  units_digit_switch,
  input  wire logic [3:0]  rate_switch,
  // Node selection
  output logic      [5:0]  station_addr,
  output logic      [1:0]  bitrate_code,
  output logic             cfg_valid,
  // Status LED
  output logic             led_green,
  output logic             led_red,
  // Interrupt
  output logic             irq
);

  // ==========================================================================
  // Registers
  logic [9:0]         net_ff;
  logic [5:0]         stage_addr_ff, saved_addr_ff;
  logic [1:0]         stage_rate_ff, saved_rate_ff;
  logic               restart_ff;
  logic [FNC_IRQ_W-1:0] irq_st_ff, irq_mk_ff;
  logic [31:0]        blink_ff;
  logic               blink_ph_ff;
  fnc_led_t           led_ff;
  logic [5:0]         addr_ff;
  logic [1:0]         rate_ff;
  logic               sw_addr_ok_ff, sw_rate_ok_ff;

  // ==========================================================================
  // Bus decode
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic [6:0]  sw_addr;
  logic        sw_addr_ok;
  logic        sw_rate_ok;
  logic [9:0]  cmd_kb;
  logic [1:0]  kb_code;
  logic        kb_ok;
  logic        cmd_addr, cmd_rate, cmd_net_addr, cmd_net_rate, cmd_save, cmd_restart;
  logic        cmd_reject;
  logic [5:0]  wr_addr;
  logic [1:0]  wr_rate;

  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  assign mapped = paddr == FNC_OFF_CTRL || paddr == FNC_OFF_PARAM || paddr == FNC_OFF_NET ||
                  paddr == FNC_OFF_ACTIVE || paddr == FNC_OFF_IRQ_ST ||
                  paddr == FNC_OFF_IRQ_MK;

  // Two decimal digits, so 99 at most; an invalid digit is not caught and can still give a 7-bit sum of 63 or below
  assign sw_addr    = 7'(tens_digit_switch) * 7'd10 + 7'(units_digit_switch);
  assign sw_addr_ok = sw_addr <= FNC_ADDR_MAX;
  assign sw_rate_ok = rate_switch <= 4'(FNC_RATE_MAX);

  assign cmd_kb  = pwdata[FNC_RATE_KB_LSB +: 10];
  assign kb_ok   = cmd_kb == FNC_KB_125 || cmd_kb == FNC_KB_250 || cmd_kb == FNC_KB_500;
  assign kb_code = (cmd_kb == FNC_KB_500) ? 2'h2 : (cmd_kb == FNC_KB_250) ? 2'h1 : 2'h0;
  assign wr_addr = pwdata[FNC_ADDR_LSB +: 6];
  assign wr_rate = pwdata[FNC_RATE_LSB +: 2];

  always_comb begin
    logic is_ctrl;
    is_ctrl      = wr_en && paddr == FNC_OFF_CTRL;
    cmd_addr     = is_ctrl && pwdata[FNC_CTRL_ADDR_CMD];
    cmd_rate     = is_ctrl && pwdata[FNC_CTRL_RATE_CMD];
    cmd_net_addr = is_ctrl && pwdata[FNC_CTRL_NET_ADDR];
    cmd_net_rate = is_ctrl && pwdata[FNC_CTRL_NET_RATE];
    cmd_save     = is_ctrl && pwdata[FNC_CTRL_SAVE];
    cmd_restart  = is_ctrl && pwdata[FNC_CTRL_RESTART];
    // Network writes are refused while the switches are in range
    cmd_reject   = (cmd_addr && pwdata[FNC_ADDR_LSB + 6 +: 2] != 2'h0)
                || (cmd_net_addr && sw_addr_ok_ff)
                || (cmd_rate && !kb_ok)
                || (cmd_net_rate && (sw_rate_ok_ff || wr_rate > FNC_RATE_MAX));
  end

  // ==========================================================================
  // APB answer, zero wait states
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          FNC_OFF_CTRL:   prdata <= 32'h0000_0000;
          FNC_OFF_PARAM:  prdata <= {22'h0, saved_rate_ff, 2'h0, saved_addr_ff};
          FNC_OFF_NET:    prdata <= {22'h0, net_ff};
          FNC_OFF_ACTIVE: prdata <= {14'h0, sw_rate_ok_ff, sw_addr_ok_ff,
                                     6'h0, rate_ff, 2'h0, addr_ff};
          FNC_OFF_IRQ_ST: prdata <= {28'h0, irq_st_ff};
          FNC_OFF_IRQ_MK: prdata <= {28'h0, irq_mk_ff};
          default:        prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // Network state inputs from the protocol engine, written by software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      net_ff <= 10'h000;
    end else if (wr_en && paddr == FNC_OFF_NET) begin
      net_ff <= pwdata[9:0];
    end
  end

  // ==========================================================================
  // Staged parameters: terminal commands or network object writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_addr_ff <= FNC_ADDR_RST;
      stage_rate_ff <= FNC_RATE_RST;
    end else if (!cmd_reject) begin
      if (cmd_addr) begin
        stage_addr_ff <= wr_addr;
      end else if (cmd_net_addr) begin
        stage_addr_ff <= wr_addr;
      end
      if (cmd_rate) begin
        stage_rate_ff <= kb_code;
      end else if (cmd_net_rate) begin
        stage_rate_ff <= wr_rate;
      end
    end
  end

  // Saved copy stands for nonvolatile memory
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      saved_addr_ff <= FNC_ADDR_RST;
      saved_rate_ff <= FNC_RATE_RST;
    end else if (cmd_save && !cmd_reject) begin
      saved_addr_ff <= stage_addr_ff;
      saved_rate_ff <= stage_rate_ff;
    end
  end

  // ==========================================================================
  // Restart: rst_n release counts as one too
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_ff <= 1'b1;
    end else begin
      restart_ff <= cmd_restart && !cmd_reject;
    end
  end

  // Selection latched only on restart so that saves stay pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff       <= 6'h00;
      rate_ff       <= 2'h0;
      sw_addr_ok_ff <= 1'b0;
      sw_rate_ok_ff <= 1'b0;
      cfg_valid     <= 1'b0;
    end else if (restart_ff) begin
      addr_ff       <= sw_addr_ok ? sw_addr[5:0] : saved_addr_ff;
      rate_ff       <= sw_rate_ok ? rate_switch[1:0] : saved_rate_ff;
      sw_addr_ok_ff <= sw_addr_ok;
      sw_rate_ok_ff <= sw_rate_ok;
      cfg_valid     <= 1'b1;
    end
  end

  assign station_addr = addr_ff;
  assign bitrate_code = rate_ff;

  // ==========================================================================
  // Blink timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_ff    <= 32'h0000_0000;
      blink_ph_ff <= 1'b0;
    end else if (blink_ff >= 32'(BLINK_CYC - 1)) begin
      blink_ff    <= 32'h0000_0000;
      blink_ph_ff <= !blink_ph_ff;
    end else begin
      blink_ff <= blink_ff + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // LED state, red faults take priority
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_ff <= FNC_LED_OFF;
    end else if (net_ff[FNC_NET_FATAL] || net_ff[FNC_NET_DUP_ADDR] ||
                 net_ff[FNC_NET_BUS_OFF]) begin
      led_ff <= FNC_LED_RED;
    end else if (net_ff[FNC_NET_RECOV] || net_ff[FNC_NET_IO_WAIT]) begin
      led_ff <= FNC_LED_BLINK_RED;
    end else if (!net_ff[FNC_NET_ONLINE] || !net_ff[FNC_NET_DUP_DONE]) begin
      led_ff <= FNC_LED_OFF;
    end else if (net_ff[FNC_NET_CONN] && net_ff[FNC_NET_ALLOC] && net_ff[FNC_NET_CFG_OK]) begin
      led_ff <= FNC_LED_GREEN;
    end else begin
      led_ff <= FNC_LED_BLINK_GREEN;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_green <= 1'b0;
      led_red   <= 1'b0;
    end else begin
      unique case (led_ff)
        FNC_LED_OFF:         begin led_green <= 1'b0;        led_red <= 1'b0;        end
        FNC_LED_GREEN:       begin led_green <= 1'b1;        led_red <= 1'b0;        end
        FNC_LED_BLINK_GREEN: begin led_green <= blink_ph_ff; led_red <= 1'b0;        end
        FNC_LED_BLINK_RED:   begin led_green <= 1'b0;        led_red <= blink_ph_ff; end
        FNC_LED_RED:         begin led_green <= 1'b0;        led_red <= 1'b1;        end
        default:             begin led_green <= 1'b0;        led_red <= 1'b0;        end
      endcase
    end
  end

  // ==========================================================================
  // Interrupts: set wins over write-one-to-clear
  always_ff @(posedge clk or negedge rst_n) begin
    logic [FNC_IRQ_W-1:0] ev;
    logic [FNC_IRQ_W-1:0] clr;
    logic [FNC_IRQ_W-1:0] mk;
    if (!rst_n) begin
      irq_st_ff <= '0;
      irq_mk_ff <= '0;
      irq       <= 1'b0;
    end else begin
      ev  = '0;
      ev[FNC_IRQ_CMD_REJ] = cmd_reject;
      ev[FNC_IRQ_SAVED]   = cmd_save && !cmd_reject;
      ev[FNC_IRQ_RESTART] = restart_ff;
      ev[FNC_IRQ_FAULT]   = led_ff == FNC_LED_RED;
      clr = (wr_en && paddr == FNC_OFF_IRQ_ST) ? pwdata[FNC_IRQ_W-1:0] : '0;
      mk  = (wr_en && paddr == FNC_OFF_IRQ_MK) ? pwdata[FNC_IRQ_W-1:0] : irq_mk_ff;
      irq_st_ff <= (irq_st_ff & ~clr) | ev;
      irq_mk_ff <= mk;
      // New mask counts at once, so irq never lags the status and mask flops
      irq <= |(((irq_st_ff & ~clr) | ev) & mk);
    end
  end

  // ==========================================================================
  // Assertions
  a_addr_select: assert property (@(posedge clk) disable iff (!rst_n)
    restart_ff && sw_addr_ok |=> addr_ff == $past(sw_addr[5:0]))
    else $error("switch address not taken");
  a_addr_stored: assert property (@(posedge clk) disable iff (!rst_n)
    restart_ff && !sw_addr_ok |=> addr_ff == $past(saved_addr_ff))
    else $error("stored address not taken");
  a_net_addr_gate: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_net_addr && sw_addr_ok_ff && !cmd_addr |=> $stable(stage_addr_ff))
    else $error("network address accepted with valid switches");
  a_save_pending: assert property (@(posedge clk) disable iff (!rst_n)
    !restart_ff |=> $stable(addr_ff) && $stable(rate_ff))
    else $error("selection changed without restart");
  a_rate_switch: assert property (@(posedge clk) disable iff (!rst_n)
    restart_ff && sw_rate_ok |=> rate_ff == $past(rate_switch[1:0]))
    else $error("switch rate not taken");
  a_rate_stored: assert property (@(posedge clk) disable iff (!rst_n)
    restart_ff && !sw_rate_ok |=> rate_ff == $past(saved_rate_ff))
    else $error("stored rate not taken");
  a_rate_code: assert property (@(posedge clk) disable iff (!rst_n)
    stage_rate_ff <= FNC_RATE_MAX)
    else $error("rate code out of range");
  a_led_dark: assert property (@(posedge clk) disable iff (!rst_n)
    led_ff == FNC_LED_OFF |=> !led_green && !led_red)
    else $error("led lit while offline");
  a_led_green: assert property (@(posedge clk) disable iff (!rst_n)
    led_ff == FNC_LED_GREEN |=> led_green && !led_red)
    else $error("steady green missing");
  a_led_red: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(net_ff[FNC_NET_BUS_OFF]) |-> ##2 led_red && !led_green)
    else $error("bus-off not shown red");
  a_blink_red: assert property (@(posedge clk) disable iff (!rst_n)
    led_ff == FNC_LED_BLINK_RED |=> !led_green && led_red == $past(blink_ph_ff))
    else $error("blink red wrong");
  a_blink_green: assert property (@(posedge clk) disable iff (!rst_n)
    led_ff == FNC_LED_BLINK_GREEN |=> !led_red && led_green == $past(blink_ph_ff))
    else $error("blink green wrong");
  a_rate_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_rate && !cmd_reject |=> stage_rate_ff == $past(kb_code))
    else $error("rate command not staged");
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    irq == |(irq_st_ff & irq_mk_ff))
    else $error("irq does not follow masked status");
  a_unmapped_err: assert property (@(posedge clk) disable iff (!rst_n)
    psel && !penable && !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");

  c_save_restart: cover property (@(posedge clk) disable iff (!rst_n)
    cmd_save ##[1:20] cmd_restart);
  c_stored_addr:  cover property (@(posedge clk) disable iff (!rst_n)
    restart_ff && !sw_addr_ok);
  c_led_green:    cover property (@(posedge clk) disable iff (!rst_n) led_green);
  c_irq:          cover property (@(posedge clk) disable iff (!rst_n) irq);
  c_blink_red:    cover property (@(posedge clk) disable iff (!rst_n)
    led_ff == FNC_LED_BLINK_RED);

endmodule

// file: tb/fnc_net_master.sv
/*
  Partner model: the network master or setup tool that reaches the node
  over APB. It writes the address and rate attributes, saves and restarts.
  Assumes the node answers with pready and keeps one clock, clk.
*/
`timescale 1ns/100ps

module fnc_net_master
  import fnc_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // APB request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  // APB answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // ==========================================================================
  // Bus cycle
  // No cycle limit here: only the bench watchdog may end a stuck wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    xfer(1'b1, a, d, rd, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic e);
    xfer(1'b0, a, 32'h0, d, e);
  endtask

  // ==========================================================================
  // Attribute writes and the save-then-restart sequence
  task automatic net_addr(input logic [5:0] a);
    wr(FNC_OFF_CTRL, 32'h1000_0000 | {26'h0, a});
  endtask

  task automatic net_rate(input logic [1:0] c);
    wr(FNC_OFF_CTRL, 32'h2000_0000 | {22'h0, c, 8'h00});
  endtask

  task automatic save_restart();
    wr(FNC_OFF_CTRL, 32'h4000_0000);
    wr(FNC_OFF_CTRL, 32'h8000_0000);
  endtask
endmodule

// file: tb/tb_top.sv
/*
  Testbench for the node configuration block: switches, stored parameters,
  network writes, interrupt and status LED; switches are set directly, the rest through APB calls.
  Assumes the partner model in fnc_net_master and a short blink period.
*/
`timescale 1ns/100ps

module tb_top;
  import fnc_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        psel, penable, pwrite, pready, pslverr, cfg_valid;
  logic        led_green, led_red, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  logic        e;
  logic [3:0]  tens_digit_switch, units_digit_switch, rate_switch;
  logic [5:0]  station_addr;
  logic [1:0]  bitrate_code;
  int          num_errors = 0;
  int          total_checks = 0;
  logic [9:0]  nets [8] = '{10'h000, 10'h01c, 10'h01f, 10'h003, 10'h00f, 10'h023,
                             10'h103, 10'h283};
  logic [1:0]  gexp [8] = '{2'd0, 2'd0, 2'd1, 2'd2, 2'd2, 2'd0, 2'd0, 2'd0};
  logic [1:0]  rexp [8] = '{2'd0, 2'd0, 2'd0, 2'd0, 2'd0, 2'd2, 2'd1, 2'd1};
  logic [9:0]  kbs  [3] = '{FNC_KB_125, FNC_KB_250, FNC_KB_500};

  fnc_node_cfg #(.BLINK_CYC(4)) fnc_node_cfg_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tens_digit_switch(tens_digit_switch), .units_digit_switch(units_digit_switch),
    .rate_switch(rate_switch), .station_addr(station_addr), .bitrate_code(bitrate_code),
    .cfg_valid(cfg_valid), .led_green(led_green), .led_red(led_red), .irq(irq));

  fnc_net_master fnc_net_master_i (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Helpers
  task automatic sw(input logic [3:0] t, input logic [3:0] u, input logic [3:0] r);
    @(posedge clk);
    tens_digit_switch <= t;
    units_digit_switch <= u;
    rate_switch <= r;
  endtask

  task automatic restart();
    fnc_net_master_i.wr(FNC_OFF_CTRL, 32'h8000_0000);
    repeat (3) @(posedge clk);
  endtask

  task automatic sel(input logic [5:0] a, input logic [1:0] c);
    @(negedge clk);
    chk({26'h0, station_addr}, {26'h0, a});
    chk({30'h0, bitrate_code}, {30'h0, c});
  endtask

  task automatic irq_is(input logic v);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, v});
  endtask

  // Class of a light over 16 cycles: 0 dark, 1 steady, 2 blinking
  task automatic led(input logic [9:0] n, input logic [1:0] g, input logic [1:0] r);
    int gc;
    int rc;
    gc = 0;
    rc = 0;
    fnc_net_master_i.wr(FNC_OFF_NET, {22'h0, n});
    repeat (3) @(posedge clk);
    repeat (16) begin
      @(negedge clk);
      gc += (led_green === 1'b1);
      rc += (led_red === 1'b1);
    end
    chk((gc == 0) ? 0 : (gc == 16) ? 1 : 2, {30'h0, g});
    chk((rc == 0) ? 0 : (rc == 16) ? 1 : 2, {30'h0, r});
  endtask

  initial begin
    #(100 * 20000);
    num_errors++;
    report_and_stop();
  end

  // ==========================================================================
  // Tests
  initial begin
    rst_n = 1'b0;
    tens_digit_switch = 4'h1;
    units_digit_switch = 4'h0;
    rate_switch = 4'h1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({31'h0, cfg_valid}, 32'h1);
    sel(6'd10, 2'd1);
    fnc_net_master_i.rd(FNC_OFF_ACTIVE, d, e);
    chk(d, 32'h0003_010a);
    fnc_net_master_i.rd(FNC_OFF_PARAM, d, e);
    chk(d, 32'h0000_003f);
    sw(4'h2, 4'h5, 4'h0);
    repeat (4) @(posedge clk);
    sel(6'd10, 2'd1);
    for (int r = 0; r < 3; r++) begin
      sw(4'h6, 4'h3, r[3:0]);
      restart();
      sel(6'd63, r[1:0]);
    end
    // Network address refused while the switches hold a valid address
    fnc_net_master_i.wr(FNC_OFF_IRQ_MK, 32'h1);
    fnc_net_master_i.net_addr(6'd5);
    irq_is(1'b1);
    fnc_net_master_i.wr(FNC_OFF_IRQ_ST, 32'hf);
    irq_is(1'b0);
    sw(4'h6, 4'h4, 4'h3);
    restart();
    sel(6'd63, 2'd0);
    fnc_net_master_i.wr(FNC_OFF_CTRL, 32'h4400_0015);
    for (int k = 0; k < 3; k++) begin
      fnc_net_master_i.wr(FNC_OFF_CTRL, {6'h02, kbs[k], 16'h0000});
      restart();
      sel(k == 0 ? 6'd63 : 6'd21, k[1:0] == 0 ? 2'd0 : k[1:0] - 2'd1);
      fnc_net_master_i.wr(FNC_OFF_CTRL, 32'h4000_0000);
      fnc_net_master_i.rd(FNC_OFF_PARAM, d, e);
      chk(d, {22'h0, k[1:0], 8'h15});
      restart();
      sel(6'd21, k[1:0]);
    end
    fnc_net_master_i.net_addr(6'd45);
    fnc_net_master_i.net_rate(2'd1);
    fnc_net_master_i.save_restart();
    repeat (3) @(posedge clk);
    sel(6'd45, 2'd1);
    fnc_net_master_i.rd(FNC_OFF_ACTIVE, d, e);
    chk(d, 32'h0000_012d);
    fnc_net_master_i.net_rate(2'd3);
    irq_is(1'b1);
    fnc_net_master_i.rd(8'h20, d, e);
    chk(d, 32'h0);
    chk({31'h0, e}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      led(nets[i], gexp[i], rexp[i]);
    end
    report_and_stop();
  end
endmodule
